/* hdl/slot_pkg.sv */
/*
  Shared constants for the shift/logic opcode decode and timing block.
  Assumes nothing of its surroundings beyond a single clock domain.
*/
package slot_pkg;

  // Opcode byte patterns; except OP_ESCAPE and the double shifts, matched whole, the low bit is the width bit and is masked off when matching
  localparam logic [7:0] OP_SHIFT_IMM   = 8'hc0;
  localparam logic [7:0] OP_SHIFT_ONE   = 8'hd0;
  localparam logic [7:0] OP_SHIFT_CNT   = 8'hd2;
  localparam logic [7:0] OP_ESCAPE      = 8'h0f;
  localparam logic [7:0] OP_DSL_IMM     = 8'ha4;
  localparam logic [7:0] OP_DSL_CNT     = 8'ha5;
  localparam logic [7:0] OP_DSR_IMM     = 8'hac;
  localparam logic [7:0] OP_DSR_CNT     = 8'had;
  localparam logic [7:0] OP_AND_TO_MEM  = 8'h20;
  localparam logic [7:0] OP_AND_TO_REG  = 8'h22;
  localparam logic [7:0] OP_AND_ACC     = 8'h24;
  localparam logic [7:0] OP_IMM_GROUP   = 8'h80;
  localparam logic [7:0] OP_TEST_RM     = 8'h84;
  localparam logic [7:0] OP_TEST_IMM    = 8'hf6;
  localparam logic [7:0] OP_TEST_ACC    = 8'ha8;

  // Modrm fields
  localparam logic [1:0] MOD_REGISTER   = 2'h3;
  localparam logic [2:0] SEL_CROTL      = 3'h2;
  localparam logic [2:0] SEL_CROTR      = 3'h3;
  localparam logic [2:0] SEL_AND        = 3'h4;
  localparam logic [2:0] SEL_TEST       = 3'h0;

  // Clock counts, register form then memory form
  localparam logic [3:0] CYC_RC_REG     = 4'h9;
  localparam logic [3:0] CYC_RC_MEM     = 4'ha;
  localparam logic [3:0] CYC_SH_REG     = 4'h3;
  localparam logic [3:0] CYC_SH_MEM     = 4'h7;
  localparam logic [3:0] CYC_AND_RM     = 4'h7;
  localparam logic [3:0] CYC_AND_MR     = 4'h6;
  localparam logic [3:0] CYC_AND_I_REG  = 4'h2;
  localparam logic [3:0] CYC_AND_I_MEM  = 4'h7;
  localparam logic [3:0] CYC_ACC        = 4'h2;
  localparam logic [3:0] CYC_TEST_REG   = 4'h2;
  localparam logic [3:0] CYC_TEST_MEM   = 4'h5;
  localparam logic [3:0] CYC_RESET      = 4'h0;

  typedef enum logic [3:0] {
    SLOT_OP_NONE  = 4'h0,
    SLOT_OP_SHIFT = 4'h1,
    SLOT_OP_CROTL = 4'h2,
    SLOT_OP_CROTR = 4'h3,
    SLOT_OP_DSL   = 4'h4,
    SLOT_OP_DSR   = 4'h5,
    SLOT_OP_AND   = 4'h6,
    SLOT_OP_TEST  = 4'h7
  } slot_op_t;

  typedef enum logic [2:0] {
    SLOT_IDLE = 3'b001,
    SLOT_BUSY = 3'b010,
    SLOT_DONE = 3'b100
  } slot_state_t;

endpackage : slot_pkg

/* hdl/slot_dec_if.sv */
/*
  Carrier between the decoder top and its cycle timer.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface slot_dec_if;
  logic       start;
  logic [3:0] cycles;
  logic       busy;
  logic       finish;
  modport ctrl  (output start, output cycles, input busy, input finish);
  modport timer (input start, input cycles, output busy, output finish);
endinterface : slot_dec_if
`default_nettype wire

/* hdl/slot_timer.sv */
/*
  Cycle timer: runs an instruction for a given number of clocks.
  Assumes start only while not busy and a count of at least one.
*/
`timescale 1ns/1ps
`default_nettype none
module slot_timer
  import slot_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  slot_dec_if.timer tmr
);
  logic [3:0] cnt_q;
  logic       busy_q;
  logic       fin_q;

  assign tmr.busy   = busy_q;
  assign tmr.finish = fin_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q  <= CYC_RESET;
      busy_q <= 1'b0;
      fin_q  <= 1'b0;
    end else begin
      fin_q <= 1'b0;
      if (tmr.start && !busy_q) begin
        cnt_q  <= tmr.cycles - 4'h1;
        busy_q <= (tmr.cycles > 4'h1);
        fin_q  <= (tmr.cycles <= 4'h1);
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q <= 4'h1) begin
          busy_q <= 1'b0;
          fin_q  <= 1'b1;
        end
      end
    end
  end
endmodule : slot_timer
`default_nettype wire

/* hdl/slot_decoder.sv */
/*
  Decoder and execution timing for rotate-through-carry, immediate-count shifts,
  double shifts, AND and the flags-only AND compare.
  Assumes instruction bytes arrive from the prefetch logic on the same clock,
  one byte per cycle with a valid strobe, and operand size from mode logic.
*/
// Overview of operation
// - Rotate via carry by one, count or immediate: 9 clocks register, 10 memory.
// - Opcode 1100000w, modrm selects operation, 8-bit count; plain shifts 3/7.
// - 0F A4 modrm imm8 is double shift left by immediate, 3/7 clocks.
// - 0F A5 modrm is double shift left by count register, 3/7 clocks.
// - 0F AC modrm imm8 is double shift right by immediate, 3/7 clocks.
// - 0F AD modrm is double shift right by count register, 3/7 clocks.
// - AND register into memory, 0010000w with modrm, takes 2/7 clocks.
// - AND memory into register, 0010001w with modrm, takes 2/6 clocks.
// - 100000sw with modrm middle 100 is AND immediate, 2/7 clocks.
// - 0010010w then immediate is accumulator AND, no modrm, 2 clocks.
// - Flags-only compare ANDs operands, sets flags, writes no result.
// - 1000010w with modrm is flags-only AND, 2 register, 5 memory.
// - 1111011w with modrm middle 000 is flags-only AND immediate, 2/5.
// - 1010100w then immediate is accumulator flags-only AND, 2 clocks.
`timescale 1ns/1ps
`default_nettype none
module slot_decoder
  import slot_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       byteValid,
  input  wire logic [7:0] byteData,
  input  wire logic       opSize32,
  output logic            byteReady,
  output logic            instStart,
  output logic            instDone,
  output slot_op_t        instOp,
  output logic [2:0]      shiftSel,
  output logic            memOperand,
  output logic [1:0]      operandBytes,
  output logic [1:0]      immBytes,
  output logic            immSignExt,
  output logic            useCountReg,
  output logic            writeBack,
  output logic            accForm,
  output logic            illegal,
  output logic [3:0]      cycleCount
);
  typedef enum logic [5:0] {
    SLOT_F_OP  = 6'b000001,
    SLOT_F_ESC = 6'b000010,
    SLOT_F_MRM = 6'b000100,
    SLOT_F_IMM = 6'b001000,
    SLOT_F_EXE = 6'b010000,
    SLOT_F_WT  = 6'b100000
  } slot_fetch_t;

  slot_fetch_t fst_q;
  slot_op_t    op_q;
  logic [7:0]  opc_q;
  logic        esc_q;
  logic [2:0]  sel_q;
  logic        mem_q;
  logic [1:0]  wid_q;
  logic [1:0]  imm_q;
  logic [1:0]  immLeft_q;
  logic        sx_q;
  logic        cnt_q;
  logic        wb_q;
  logic        acc_q;
  logic        ill_q;
  logic [3:0]  cyc_q;
  logic        rdy_q;
  logic        start_q;
  logic        done_q;
  logic [3:0]  cyc_d;
  logic        mrmImm;
  logic        lastTake;

  slot_dec_if tif ();
  slot_timer u_timer (.clk(clk), .nrst(nrst), .tmr(tif));

  assign tif.start  = start_q;
  assign tif.cycles = cyc_q;
  assign byteReady    = rdy_q;
  assign instStart    = start_q;
  assign instDone     = done_q;
  assign instOp       = op_q;
  assign shiftSel     = sel_q;
  assign memOperand   = mem_q;
  assign operandBytes = wid_q;
  assign immBytes     = imm_q;
  assign immSignExt   = sx_q;
  assign useCountReg  = cnt_q;
  assign writeBack    = wb_q;
  assign accForm      = acc_q;
  assign illegal      = ill_q;
  assign cycleCount   = cyc_q;

  // Operand width code: 0 byte, 1 word, 2 doubleword
  function automatic logic [1:0] widthOf(input logic w, input logic s32);
    widthOf = !w ? 2'h0 : (s32 ? 2'h2 : 2'h1);
  endfunction : widthOf

  // Full-width immediate length in bytes minus one
  function automatic logic [1:0] immLen(input logic [1:0] wd);
    immLen = (wd == 2'h2) ? 2'h3 : wd;
  endfunction : immLen

  // Ready drops with the byte that ends an instruction, so none is offered during execute
  always_comb begin
    mrmImm   = esc_q ? !opc_q[0]
                     : (opc_q[7:1] == OP_SHIFT_IMM[7:1]) || (opc_q[7:2] == OP_IMM_GROUP[7:2])
                       || (opc_q[7:1] == OP_TEST_IMM[7:1]);
    lastTake = byteValid && rdy_q
               && ((fst_q == SLOT_F_MRM && !mrmImm) || (fst_q == SLOT_F_IMM && immLeft_q == 2'h0));
  end

  // Clock count from operation and operand kind; never depends on mode
  always_comb begin
    cyc_d = CYC_RESET;
    case (op_q)
      SLOT_OP_CROTL, SLOT_OP_CROTR: cyc_d = mem_q ? CYC_RC_MEM : CYC_RC_REG;
      SLOT_OP_SHIFT:            cyc_d = mem_q ? CYC_SH_MEM : CYC_SH_REG;
      SLOT_OP_DSL, SLOT_OP_DSR: cyc_d = mem_q ? CYC_SH_MEM : CYC_SH_REG;
      SLOT_OP_AND: begin
        if (acc_q)
          cyc_d = CYC_ACC;
        else if (opc_q[7:2] == OP_IMM_GROUP[7:2])
          cyc_d = mem_q ? CYC_AND_I_MEM : CYC_AND_I_REG;
        else if (opc_q[7:1] == OP_AND_TO_REG[7:1])
          cyc_d = mem_q ? CYC_AND_MR : CYC_AND_I_REG;
        else
          cyc_d = mem_q ? CYC_AND_RM : CYC_AND_I_REG;
      end
      SLOT_OP_TEST: cyc_d = acc_q ? CYC_ACC : (mem_q ? CYC_TEST_MEM : CYC_TEST_REG);
      default:      cyc_d = CYC_RESET;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fst_q     <= SLOT_F_OP;
      op_q      <= SLOT_OP_NONE;
      opc_q     <= 8'h00;
      esc_q     <= 1'b0;
      sel_q     <= 3'h0;
      mem_q     <= 1'b0;
      wid_q     <= 2'h0;
      imm_q     <= 2'h0;
      immLeft_q <= 2'h0;
      sx_q      <= 1'b0;
      cnt_q     <= 1'b0;
      wb_q      <= 1'b0;
      acc_q     <= 1'b0;
      ill_q     <= 1'b0;
      cyc_q     <= CYC_RESET;
      rdy_q     <= 1'b0;
      start_q   <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      start_q <= 1'b0;
      done_q  <= tif.finish;
      rdy_q   <= (fst_q != SLOT_F_EXE) && (fst_q != SLOT_F_WT) && !lastTake && !tif.busy;
      case (fst_q)
        SLOT_F_OP: begin
          if (byteValid && rdy_q) begin
            opc_q <= byteData;
            esc_q <= 1'b0;
            ill_q <= 1'b0;
            wid_q <= widthOf(byteData[0], opSize32);
            sx_q  <= 1'b0;
            cnt_q <= 1'b0;
            acc_q <= 1'b0;
            mem_q <= 1'b0;
            wb_q  <= 1'b1;
            imm_q <= 2'h0;
            if (byteData == OP_ESCAPE) begin
              fst_q <= SLOT_F_ESC;
            end else if (byteData[7:1] == OP_AND_ACC[7:1]
                         || byteData[7:1] == OP_TEST_ACC[7:1]) begin
              op_q      <= (byteData[7:1] == OP_AND_ACC[7:1]) ? SLOT_OP_AND : SLOT_OP_TEST;
              wb_q      <= (byteData[7:1] == OP_AND_ACC[7:1]);
              acc_q     <= 1'b1;
              imm_q     <= immLen(widthOf(byteData[0], opSize32));
              immLeft_q <= immLen(widthOf(byteData[0], opSize32));
              fst_q     <= SLOT_F_IMM;
            end else if (byteData[7:1] == OP_SHIFT_IMM[7:1]
                         || byteData[7:1] == OP_SHIFT_ONE[7:1]
                         || byteData[7:1] == OP_SHIFT_CNT[7:1]
                         || byteData[7:1] == OP_AND_TO_MEM[7:1]
                         || byteData[7:1] == OP_AND_TO_REG[7:1]
                         || byteData[7:2] == OP_IMM_GROUP[7:2]
                         || byteData[7:1] == OP_TEST_RM[7:1]
                         || byteData[7:1] == OP_TEST_IMM[7:1]) begin
              fst_q <= SLOT_F_MRM;
            end else begin
              ill_q <= 1'b1;
            end
          end
        end
        SLOT_F_ESC: begin
          if (byteValid && rdy_q) begin
            esc_q <= 1'b1;
            opc_q <= byteData;
            wid_q <= widthOf(1'b1, opSize32);
            if (byteData == OP_DSL_IMM || byteData == OP_DSL_CNT
                || byteData == OP_DSR_IMM || byteData == OP_DSR_CNT) begin
              fst_q <= SLOT_F_MRM;
            end else begin
              ill_q <= 1'b1;
              fst_q <= SLOT_F_OP;
            end
          end
        end
        SLOT_F_MRM: begin
          if (byteValid && rdy_q) begin
            mem_q <= (byteData[7:6] != MOD_REGISTER);
            sel_q <= byteData[5:3];
            fst_q <= SLOT_F_EXE;
            if (esc_q) begin
              op_q  <= opc_q[3] ? SLOT_OP_DSR : SLOT_OP_DSL;
              cnt_q <= opc_q[0];
              if (!opc_q[0]) begin
                imm_q     <= 2'h0;
                immLeft_q <= 2'h0;
                fst_q     <= SLOT_F_IMM;
              end
            end else if (opc_q[7:5] == OP_SHIFT_IMM[7:5]) begin
              // Other shift selections are only counted by the generic shift timing
              op_q  <= (byteData[5:3] == SEL_CROTL) ? SLOT_OP_CROTL :
                       (byteData[5:3] == SEL_CROTR) ? SLOT_OP_CROTR : SLOT_OP_SHIFT;
              cnt_q <= (opc_q[7:1] == OP_SHIFT_CNT[7:1]);
              if (opc_q[7:1] == OP_SHIFT_IMM[7:1]) begin
                imm_q     <= 2'h0;
                immLeft_q <= 2'h0;
                fst_q     <= SLOT_F_IMM;
              end
            end else if (opc_q[7:2] == OP_IMM_GROUP[7:2]) begin
              if (byteData[5:3] == SEL_AND) begin
                op_q      <= SLOT_OP_AND;
                sx_q      <= opc_q[1];
                imm_q     <= opc_q[1] ? 2'h0 : immLen(wid_q);
                immLeft_q <= opc_q[1] ? 2'h0 : immLen(wid_q);
                fst_q     <= SLOT_F_IMM;
              end else begin
                ill_q <= 1'b1;
                fst_q <= SLOT_F_OP;
              end
            end else if (opc_q[7:1] == OP_TEST_IMM[7:1]) begin
              if (byteData[5:3] == SEL_TEST) begin
                op_q      <= SLOT_OP_TEST;
                wb_q      <= 1'b0;
                imm_q     <= immLen(wid_q);
                immLeft_q <= immLen(wid_q);
                fst_q     <= SLOT_F_IMM;
              end else begin
                ill_q <= 1'b1;
                fst_q <= SLOT_F_OP;
              end
            end else if (opc_q[7:1] == OP_TEST_RM[7:1]) begin
              op_q <= SLOT_OP_TEST;
              wb_q <= 1'b0;
            end else begin
              op_q <= SLOT_OP_AND;
            end
          end
        end
        SLOT_F_IMM: begin
          if (byteValid && rdy_q) begin
            immLeft_q <= immLeft_q - 2'h1;
            if (immLeft_q == 2'h0)
              fst_q <= SLOT_F_EXE;
          end
        end
        SLOT_F_EXE: begin
          cyc_q   <= cyc_d;
          start_q <= 1'b1;
          fst_q   <= SLOT_F_WT;
        end
        SLOT_F_WT: begin
          if (tif.finish)
            fst_q <= SLOT_F_OP;
        end
        default: fst_q <= SLOT_F_OP;
      endcase
    end
  end
endmodule : slot_decoder
`default_nettype wire

/* verification/slot_decoder_assertions.sv */
/*
  Checker for the shift/logic opcode decoder, bound to its top.
  Assumes decoded outputs stand from instStart until the next instruction.
*/
`timescale 1ns/1ps
`default_nettype none
module slot_decoder_chk
  import slot_pkg::*;
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       byteValid,
  input wire logic [7:0] byteData,
  input wire logic       opSize32,
  input wire logic       byteReady,
  input wire logic       instStart,
  input wire logic       instDone,
  input wire slot_op_t   instOp,
  input wire logic [2:0] shiftSel,
  input wire logic       memOperand,
  input wire logic [1:0] operandBytes,
  input wire logic [1:0] immBytes,
  input wire logic       immSignExt,
  input wire logic       useCountReg,
  input wire logic       writeBack,
  input wire logic       accForm,
  input wire logic       illegal,
  input wire logic [3:0] cycleCount
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Edges elapsed since the start pulse of the running instruction
  logic       run_q;
  logic [4:0] cnt_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      run_q <= 1'b0;
      cnt_q <= 5'h00;
    end else if (instStart) begin
      run_q <= 1'b1;
      cnt_q <= 5'h01;
    end else if (run_q) begin
      run_q <= !instDone;
      cnt_q <= cnt_q + 5'h01;
    end
  end

  property p_rc; instStart && instOp inside {SLOT_OP_CROTL, SLOT_OP_CROTR}
    |-> cycleCount == (memOperand ? 4'ha : 4'h9); endproperty
  a_rc: assert property (p_rc) else $error("via-carry count wrong");
  property p_sh; instStart && instOp inside {SLOT_OP_SHIFT, SLOT_OP_DSL, SLOT_OP_DSR}
    |-> cycleCount == (memOperand ? 4'h7 : 4'h3); endproperty
  a_sh: assert property (p_sh) else $error("shift count wrong");
  property p_dimm; instStart && instOp inside {SLOT_OP_DSL, SLOT_OP_DSR} && !useCountReg
    |-> immBytes == 2'h0; endproperty
  a_dimm: assert property (p_dimm) else $error("double shift count length wrong");
  property p_tst; instStart && instOp == SLOT_OP_TEST && !accForm
    |-> cycleCount == (memOperand ? 4'h5 : 4'h2); endproperty
  a_tst: assert property (p_tst) else $error("flags-only count wrong");
  property p_nowb; instStart |-> writeBack == (instOp != SLOT_OP_TEST); endproperty
  a_nowb: assert property (p_nowb) else $error("write-back flag wrong");
  property p_acc; instStart && accForm |-> cycleCount == 4'h2 && !memOperand; endproperty
  a_acc: assert property (p_acc) else $error("short form wrong");
  property p_sx; instStart && immSignExt |-> immBytes == 2'h0 && instOp == SLOT_OP_AND;
  endproperty
  a_sx: assert property (p_sx) else $error("sign-extend immediate wrong");
  property p_at; instDone |-> run_q && cnt_q == {1'b0, cycleCount} + 5'h01; endproperty
  a_at: assert property (p_at) else $error("done came early");
  property p_due; run_q && cnt_q == {1'b0, cycleCount} + 5'h01 |-> instDone; endproperty
  a_due: assert property (p_due) else $error("done came late");
  property p_busy; instStart |-> !byteReady ##1 !instStart; endproperty
  a_busy: assert property (p_busy) else $error("start not a pulse");
  property p_rdy; instStart |-> !$past(byteReady); endproperty
  a_rdy: assert property (p_rdy) else $error("ready offered during execute");
endmodule : slot_decoder_chk

bind slot_decoder slot_decoder_chk u_chk (.clk(clk), .nrst(nrst), .byteValid(byteValid),
  .byteData(byteData), .opSize32(opSize32), .byteReady(byteReady), .instStart(instStart),
  .instDone(instDone), .instOp(instOp), .shiftSel(shiftSel), .memOperand(memOperand),
  .operandBytes(operandBytes), .immBytes(immBytes), .immSignExt(immSignExt),
  .useCountReg(useCountReg), .writeBack(writeBack), .accForm(accForm),
  .illegal(illegal), .cycleCount(cycleCount));
`default_nettype wire

/* verification/tb.sv */
/*
  Self-checking bench for the shift/logic opcode decoder.
  Assumes the decoder's byte handshake and its fixed execution timing.
*/
`timescale 1ns/1ps
`default_nettype none
module tb
  import slot_pkg::*;
;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       byteValid = 1'b0;
  logic [7:0] byteData = 8'h00;
  logic       opSize32 = 1'b0;
  logic       byteReady, instStart, instDone, memOperand, immSignExt;
  logic       useCountReg, writeBack, accForm, illegal;
  slot_op_t   instOp;
  logic [2:0] shiftSel;
  logic [1:0] operandBytes, immBytes;
  logic [3:0] cycleCount;
  int         fails = 0;
  int         num_checks = 0;

  always #4 clk = ~clk;

  slot_decoder dut (.clk(clk), .nrst(nrst), .byteValid(byteValid), .byteData(byteData),
    .opSize32(opSize32), .byteReady(byteReady), .instStart(instStart), .instDone(instDone),
    .instOp(instOp), .shiftSel(shiftSel), .memOperand(memOperand),
    .operandBytes(operandBytes), .immBytes(immBytes), .immSignExt(immSignExt),
    .useCountReg(useCountReg), .writeBack(writeBack), .accForm(accForm),
    .illegal(illegal), .cycleCount(cycleCount));

  task results;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // Counts falling edges until the selected output is high
  task waitFor(input int w, output int k);
    for (k = 1; k <= 40; k++) begin
      @(negedge clk);
      if ((w == 0 && byteReady === 1'b1) || (w == 1 && instStart === 1'b1) ||
          (w == 2 && instDone === 1'b1) || (w == 3 && illegal === 1'b1)) break;
    end
    if (k > 40) begin
      fails++;
      $display("BAD wait %0d exp 1 got 0", w);
      results();
    end
  endtask : waitFor

  // Bytes are right-aligned in bs, first byte most significant
  task send(input logic [47:0] bs, input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      byteValid <= 1'b1;
      byteData  <= bs[8*(n-1-i) +: 8];
      waitFor(0, k);
      @(posedge clk);
    end
    byteValid <= 1'b0;
  endtask : send

  // Flags fl are sign-extend, count register, write-back, short form
  task run(input logic [47:0] bs, input int n, input slot_op_t op, input logic [3:0] cyc,
           input logic m, input logic [1:0] ob, input logic [1:0] ib, input logic [3:0] fl);
    int k;
    send(bs, n);
    waitFor(1, k);
    chk("decode", {op, cyc, m, ob, ib, fl}, {instOp, cycleCount, memOperand, operandBytes,
        immBytes, immSignExt, useCountReg, writeBack, accForm});
    waitFor(2, k);
    chk("cycles", {13'h0000, cyc + 4'h1}, 17'(k));
    @(posedge clk);
  endtask : run

  task t_rotate;
    opSize32 <= 1'h1;
    run(48'hd1d0, 2, SLOT_OP_CROTL, 4'h9, 1'h0, 2'h2, 2'h0, 4'h2);
    chk("shiftSel", 17'h00002, {14'h0000, shiftSel});
    run(48'hc01805, 3, SLOT_OP_CROTR, 4'ha, 1'h1, 2'h0, 2'h0, 4'h2);
    chk("shiftSel", 17'h00003, {14'h0000, shiftSel});
    run(48'hd218, 2, SLOT_OP_CROTR, 4'ha, 1'h1, 2'h0, 2'h0, 4'h6);
  endtask : t_rotate

  task t_shift;
    run(48'hc1e003, 3, SLOT_OP_SHIFT, 4'h3, 1'h0, 2'h2, 2'h0, 4'h2);
    chk("shiftSel", 17'h00004, {14'h0000, shiftSel});
    run(48'hc03804, 3, SLOT_OP_SHIFT, 4'h7, 1'h1, 2'h0, 2'h0, 4'h2);
    chk("shiftSel", 17'h00007, {14'h0000, shiftSel});
    opSize32 <= 1'h0;
    run(48'h0fa4c004, 4, SLOT_OP_DSL, 4'h3, 1'h0, 2'h1, 2'h0, 4'h2);
    run(48'h0fa500, 3, SLOT_OP_DSL, 4'h7, 1'h1, 2'h1, 2'h0, 4'h6);
    run(48'h0fac0008, 4, SLOT_OP_DSR, 4'h7, 1'h1, 2'h1, 2'h0, 4'h2);
    run(48'h0fadc0, 3, SLOT_OP_DSR, 4'h3, 1'h0, 2'h1, 2'h0, 4'h6);
  endtask : t_shift

  task t_and;
    run(48'h251122, 3, SLOT_OP_AND, 4'h2, 1'h0, 2'h1, 2'h1, 4'h3);
    opSize32 <= 1'h1;
    run(48'h2000, 2, SLOT_OP_AND, 4'h7, 1'h1, 2'h0, 2'h0, 4'h2);
    run(48'h2300, 2, SLOT_OP_AND, 4'h6, 1'h1, 2'h2, 2'h0, 4'h2);
    run(48'h83e005, 3, SLOT_OP_AND, 4'h2, 1'h0, 2'h2, 2'h0, 4'ha);
    run(48'h812011223344, 6, SLOT_OP_AND, 4'h7, 1'h1, 2'h2, 2'h3, 4'h2);
  endtask : t_and

  task t_test;
    run(48'h84c0, 2, SLOT_OP_TEST, 4'h2, 1'h0, 2'h0, 2'h0, 4'h0);
    run(48'h8500, 2, SLOT_OP_TEST, 4'h5, 1'h1, 2'h2, 2'h0, 4'h0);
    run(48'hf60055, 3, SLOT_OP_TEST, 4'h5, 1'h1, 2'h0, 2'h0, 4'h0);
    run(48'hf7c011223344, 6, SLOT_OP_TEST, 4'h2, 1'h0, 2'h2, 2'h3, 4'h0);
    run(48'ha812, 2, SLOT_OP_TEST, 4'h2, 1'h0, 2'h0, 2'h0, 4'h1);
  endtask : t_test

  // Immediate group with an OR selection lies outside this slice
  task t_illegal;
    int k;
    send(48'h80c8, 2);
    waitFor(3, k);
    chk("illegal", 17'h00001, {16'h0000, illegal});
    @(posedge clk);
    run(48'ha812, 2, SLOT_OP_TEST, 4'h2, 1'h0, 2'h0, 2'h0, 4'h1);
    chk("illegal", 17'h00000, {16'h0000, illegal});
    send(48'hf608, 2);
    waitFor(3, k);
    chk("illegal", 17'h00001, {16'h0000, illegal});
    @(posedge clk);
    send(48'h0f10, 2);
    waitFor(3, k);
    chk("illegal", 17'h00001, {16'h0000, illegal});
    @(posedge clk);
  endtask : t_illegal

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_rotate();
    t_shift();
    t_and();
    t_test();
    t_illegal();
    results();
  end
endmodule : tb
`default_nettype wire
